// ==== pkg/watchdog_pkg.sv ====
// constants, types and register map of the supervisor window watchdog
package watchdog_pkg;

  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CNT_W   = 32;

  // delay source codes on the two timing-select pins
  localparam logic [1:0] SEL_CAP    = 2'h0;
  localparam logic [1:0] SEL_PULLUP = 2'h1;
  localparam logic [1:0] SEL_OPEN   = 2'h2;

  // factory preset times in microseconds and their cycle counts
  localparam int unsigned RST_PULLUP_US   = 10;
  localparam int unsigned RST_OPEN_US     = 200;
  localparam int unsigned UPPER_PULLUP_US = 1000;
  localparam int unsigned UPPER_OPEN_US   = 5000;
  localparam logic [CNT_W-1:0] RST_PULLUP_CYC = CNT_W'(RST_PULLUP_US * CLK_MHZ);
  localparam int unsigned RST_OPEN_CYC_DEF    = RST_OPEN_US * CLK_MHZ;
  localparam int unsigned UPPER_PULLUP_CYC_DEF = UPPER_PULLUP_US * CLK_MHZ;
  localparam int unsigned UPPER_OPEN_CYC_DEF  = UPPER_OPEN_US * CLK_MHZ;

  // strap code {window_strap_b, window_strap_a} and lower-bound shifts
  localparam logic [1:0] STRAP_DISABLE = 2'h1;
  localparam logic [1:0] STRAP_RATIO8  = 2'h0;
  localparam logic [1:0] STRAP_RATIO2  = 2'h2;
  localparam logic [4:0] SHIFT_RATIO8  = 5'h03;
  localparam logic [4:0] SHIFT_RATIO2  = 5'h01;
  localparam logic [4:0] SHIFT_RATIO4  = 5'h02;

  // register byte addresses
  localparam logic [7:0] ADDR_CAP_RST   = 8'h00;
  localparam logic [7:0] ADDR_CAP_UPPER = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_LIVE      = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;

  localparam logic [CNT_W-1:0] CAP_RST_RESET   = 32'h0000_0100;
  localparam logic [CNT_W-1:0] CAP_UPPER_RESET = 32'h0000_1000;
  localparam logic [3:0]       IRQ_EN_RESET    = 4'h0;

  // event bit positions in status, clear and enable
  localparam int unsigned EV_RAIL    = 0;
  localparam int unsigned EV_LATE    = 1;
  localparam int unsigned EV_EARLY   = 2;
  localparam int unsigned EV_RELEASE = 3;
  localparam int unsigned EV_N       = 4;

  typedef enum logic [1:0] {st_hold, st_run, st_fault} mode_type;

endpackage

// ==== pkg/count_if.sv ====
// clear and count between a user and an elapsed-cycle counter
`timescale 1ns/1ps
`default_nettype none
interface count_if;
  import watchdog_pkg::*;
  logic             clear;
  logic [CNT_W-1:0] count;
  modport counter (input clear, output count);
  modport user    (output clear, input count);
endinterface
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rstn,  // async reset, active low
  input  wire logic [W-1:0] d,     // pin levels
  output logic      [W-1:0] q      // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/span_counter.sv ====
// saturating elapsed-cycle counter, zero in the cycle after clear
`timescale 1ns/1ps
`default_nettype none
module span_counter (
  input  wire logic clk,   // system clock
  input  wire logic rstn,  // async reset, active low
  count_if.counter  cnt    // clear in, count out
);
  import watchdog_pkg::*;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt.count <= '0;
    end else if (cnt.clear) begin
      cnt.count <= '0;
    end else if (cnt.count != '1) begin
      cnt.count <= cnt.count + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/supervisor_window_watchdog.sv ====
// reset supervisor and window watchdog with a wishbone register slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset is pulled low whenever the rail is flagged under or over voltage.
// - once the rail is good the reset delay counts and reset releases only at its end.
// - after power-on reset stays low until the rail is good and a full delay has passed.
// - the reset delay comes from the capacitor setting or a preset chosen by its select pin.
// - the upper window bound comes from the capacitor setting or a preset chosen by its pin.
// - the lower window bound is derived from the two window straps.
// - the straps with the timing pin pick the window ratio and timeout or disable the watchdog.
// - kick activity is ignored while reset or fault is asserted or the watchdog is off.
// - a timeout pulls the fault output low for one reset delay, then releases it.
// - the fault output asserts only while reset is released and is released during reset.
module supervisor_window_watchdog
  import watchdog_pkg::*;
#(
  parameter int unsigned RST_OPEN_CYC     = watchdog_pkg::RST_OPEN_CYC_DEF,
  parameter int unsigned UPPER_PULLUP_CYC = watchdog_pkg::UPPER_PULLUP_CYC_DEF,
  parameter int unsigned UPPER_OPEN_CYC   = watchdog_pkg::UPPER_OPEN_CYC_DEF
) (
  input  wire logic        clk,                      // 40 MHz clock
  input  wire logic        rstn,                     // power-on reset, active low
  input  wire logic        undervoltage_flag,        // rail below threshold
  input  wire logic        overvoltage_flag,         // rail above threshold
  input  wire logic        kick_input,               // watchdog kick pin
  input  wire logic        window_strap_a,           // window strap low bit
  input  wire logic        window_strap_b,           // window strap high bit
  input  wire logic [1:0]  reset_delay_select_pin,   // reset delay source code
  input  wire logic [1:0]  window_timing_select_pin, // upper bound source code
  output logic             reset_out,                // open-drain data, always low
  output logic             reset_oe,                 // high while reset pulled low
  output logic             kick_fault_output,        // open-drain data, always low
  output logic             kick_fault_oe,            // high while fault pulled low
  output logic             irq,                      // enabled status pending
  input  wire logic        wb_cyc_i,                 // wishbone cycle
  input  wire logic        wb_stb_i,                 // wishbone strobe
  input  wire logic        wb_we_i,                  // wishbone write
  input  wire logic [7:0]  wb_adr_i,                 // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                 // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,                 // wishbone write data
  output logic [31:0]      wb_dat_o,                 // wishbone read data
  output logic             wb_ack_o                  // wishbone acknowledge
);
  import watchdog_pkg::*;

  typedef struct packed {
    mode_type         mode;
    logic             rst_oe;
    logic             fault_oe;
    logic             kick_prev;
    logic [EV_N-1:0]  status;
    logic [EV_N-1:0]  irq_en;
    logic [CNT_W-1:0] cap_rst;
    logic [CNT_W-1:0] cap_upper;
    logic             ack;
    logic [31:0]      dat;
    logic             irq;
  } state_type;

  state_type q;
  state_type next_q;

  logic [2:0] flags_s;
  logic [1:0] strap_s;
  logic [1:0] rsel_s;
  logic [1:0] wsel_s;
  logic       rail_ok;
  logic       kick_fall;
  logic       disabled;
  logic [4:0] lower_shift;
  logic [CNT_W-1:0] rst_delay;
  logic [CNT_W-1:0] upper;
  logic [CNT_W-1:0] lower;
  logic             wb_req;

  count_if rst_cnt ();
  count_if win_cnt ();

  pin_sync #(.W(3)) flag_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({kick_input, overvoltage_flag, undervoltage_flag}),
    .q    (flags_s)
  );
  pin_sync #(.W(6)) cfg_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({window_timing_select_pin, reset_delay_select_pin, window_strap_b, window_strap_a}),
    .q    ({wsel_s, rsel_s, strap_s})
  );
  span_counter rst_timer (.clk(clk), .rstn(rstn), .cnt(rst_cnt));
  span_counter win_timer (.clk(clk), .rstn(rstn), .cnt(win_cnt));

  assign rail_ok   = !flags_s[0] && !flags_s[1];
  assign kick_fall = q.kick_prev && !flags_s[2];
  assign wb_req    = wb_cyc_i && wb_stb_i && !q.ack;

  // delay and window decode from the timing pins and straps
  always_comb begin
    case (rsel_s)
      SEL_CAP:    rst_delay = q.cap_rst;
      SEL_PULLUP: rst_delay = RST_PULLUP_CYC;
      default:    rst_delay = CNT_W'(RST_OPEN_CYC);
    endcase
    case (wsel_s)
      SEL_CAP:    upper = q.cap_upper;
      SEL_PULLUP: upper = CNT_W'(UPPER_PULLUP_CYC);
      default:    upper = CNT_W'(UPPER_OPEN_CYC);
    endcase
    disabled = (strap_s == STRAP_DISABLE);
    case (strap_s)
      STRAP_RATIO8: lower_shift = SHIFT_RATIO8;
      STRAP_RATIO2: lower_shift = SHIFT_RATIO2;
      default:      lower_shift = SHIFT_RATIO4;
    endcase
    lower = upper >> lower_shift;
  end

  always_comb begin
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;
    next_q          = q;
    ev              = '0;
    clr             = '0;
    rst_cnt.clear   = 1'b1;
    win_cnt.clear   = 1'b0;
    next_q.kick_prev = flags_s[2];

    if (!rail_ok) begin
      // rail fault overrides everything and releases the fault pin
      next_q.mode     = st_hold;
      next_q.rst_oe   = 1'b1;
      next_q.fault_oe = 1'b0;
      ev[EV_RAIL]     = !q.rst_oe;
    end else begin
      case (q.mode)
        st_hold: begin
          rst_cnt.clear = 1'b0;
          win_cnt.clear = 1'b1;
          if (rst_cnt.count >= rst_delay) begin
            next_q.mode   = st_run;
            next_q.rst_oe = 1'b0;
            ev[EV_RELEASE] = 1'b1;
          end
        end
        st_run: begin
          if (disabled) begin
            win_cnt.clear = 1'b1;
          end else if (kick_fall && win_cnt.count < lower) begin
            next_q.mode     = st_fault;
            next_q.fault_oe = 1'b1;
            win_cnt.clear   = 1'b1;
            ev[EV_EARLY]    = 1'b1;
          end else if (kick_fall) begin
            win_cnt.clear = 1'b1;
          end else if (win_cnt.count >= upper) begin
            next_q.mode     = st_fault;
            next_q.fault_oe = 1'b1;
            win_cnt.clear   = 1'b1;
            ev[EV_LATE]     = 1'b1;
          end
        end
        st_fault: begin
          // kicks are not looked at here; fault lasts one reset delay
          if (win_cnt.count >= rst_delay) begin
            next_q.mode     = st_run;
            next_q.fault_oe = 1'b0;
            win_cnt.clear   = 1'b1;
          end
        end
        default: begin
          next_q.mode   = st_hold;
          next_q.rst_oe = 1'b1;
        end
      endcase
    end

    // wishbone slave: ack one cycle after the request, unmapped reads zero
    next_q.ack = wb_req;
    next_q.dat = '0;
    if (wb_req && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          case (wb_adr_i)
            ADDR_CAP_RST:   next_q.cap_rst[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            ADDR_CAP_UPPER: next_q.cap_upper[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (wb_sel_i[0] && wb_adr_i == ADDR_IRQ_CLEAR) begin
        clr = wb_dat_i[EV_N-1:0];
      end
      if (wb_sel_i[0] && wb_adr_i == ADDR_IRQ_EN) begin
        next_q.irq_en = wb_dat_i[EV_N-1:0];
      end
    end else if (wb_req) begin
      case (wb_adr_i)
        ADDR_CAP_RST:   next_q.dat = q.cap_rst;
        ADDR_CAP_UPPER: next_q.dat = q.cap_upper;
        ADDR_STATUS:    next_q.dat = {28'h0000000, q.status};
        ADDR_LIVE:      next_q.dat = {26'h0, disabled, rail_ok, q.fault_oe, q.rst_oe,
                                      q.mode};
        ADDR_IRQ_EN:    next_q.dat = {28'h0000000, q.irq_en};
        default:        next_q.dat = '0;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_q.status = (q.status & ~clr) | ev;
    next_q.irq    = |(next_q.status & next_q.irq_en);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q           <= '0;
      q.mode      <= st_hold;
      q.rst_oe    <= 1'b1;
      q.irq_en    <= IRQ_EN_RESET;
      q.cap_rst   <= CAP_RST_RESET;
      q.cap_upper <= CAP_UPPER_RESET;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_out         <= 1'b0;
      kick_fault_output <= 1'b0;
    end else begin
      reset_out         <= 1'b0;
      kick_fault_output <= 1'b0;
    end
  end

  assign reset_oe      = q.rst_oe;
  assign kick_fault_oe = q.fault_oe;
  assign irq           = q.irq;
  assign wb_ack_o      = q.ack;
  assign wb_dat_o      = q.dat;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  rail_low_a: assert property (!rail_ok |=> reset_oe && !kick_fault_oe)
    else $error("reset not asserted on bad rail");
  release_delay_a: assert property ($fell(reset_oe) |->
    $past(rst_cnt.count) >= $past(rst_delay) && $past(rail_ok))
    else $error("reset released before delay");
  fault_in_run_a: assert property (kick_fault_oe |-> !reset_oe)
    else $error("fault asserted while reset low");
  fault_len_a: assert property ($fell(kick_fault_oe) && !reset_oe |->
    $past(win_cnt.count) >= $past(rst_delay))
    else $error("fault released early");
  early_kick_a: assert property (q.mode == st_run && rail_ok && !disabled && kick_fall &&
    win_cnt.count < lower |=> kick_fault_oe)
    else $error("early kick not faulted");
  late_kick_a: assert property (q.mode == st_run && rail_ok && !disabled && !kick_fall &&
    win_cnt.count >= upper |=> kick_fault_oe)
    else $error("missing kick not faulted");
  disabled_quiet_a: assert property (q.mode == st_run && disabled && !kick_fault_oe |=>
    !kick_fault_oe)
    else $error("fault while watchdog disabled");
  open_drain_a: assert property (!reset_out && !kick_fault_output)
    else $error("open-drain output driven high");
  cap_select_a: assert property (rsel_s == SEL_CAP && $stable(q.cap_rst) |->
    rst_delay == q.cap_rst)
    else $error("capacitor delay not selected");

  release_c: cover property ($fell(reset_oe));
  early_c:   cover property (q.status[EV_EARLY]);
  late_c:    cover property (q.status[EV_LATE]);
  kick_ok_c: cover property (q.mode == st_run && kick_fall && win_cnt.count >= lower);
endmodule
`default_nettype wire

// ==== sim/host_kicker.sv ====
// host model that kicks the watchdog input at a set period
`timescale 1ns/1ps
`default_nettype none
module host_kicker (
  input  wire logic        clk,    // system clock
  input  wire logic        hold,   // host held in reset by the supervisor
  input  wire logic        en,     // kicking enabled
  input  wire logic [15:0] period, // cycles between falling edges
  output logic             kick    // drives the kick input
);
  logic [15:0] cnt;
  initial begin
    cnt  = 16'h0000;
    kick = 1'b1;
  end
  always @(posedge clk) begin
    if (hold || !en) begin
      cnt  <= 16'h0000;
      kick <= 1'b1;
    end else if (cnt >= period - 16'h0001) begin
      cnt  <= 16'h0000;
      kick <= 1'b0;
    end else begin
      cnt <= cnt + 16'h0001;
      if (cnt == 16'h0003) kick <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the supervisor window watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
  import watchdog_pkg::*;
  localparam int RC = 40;
  logic        clk, rstn, uv, ov, kick, sa, sb, en, cyc, stb, we, ack, irq;
  logic        r_od, r_oe, f_od, f_oe;
  logic [1:0]  rsel, wsel;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [15:0] period;
  logic [31:0] wdat, rdat, q;
  int          fails, num_checks, n;

  supervisor_window_watchdog #(.RST_OPEN_CYC(RC), .UPPER_PULLUP_CYC(400),
    .UPPER_OPEN_CYC(800)) dut_u (.clk(clk), .rstn(rstn), .undervoltage_flag(uv),
    .overvoltage_flag(ov), .kick_input(kick), .window_strap_a(sa), .window_strap_b(sb),
    .reset_delay_select_pin(rsel), .window_timing_select_pin(wsel), .reset_out(r_od),
    .reset_oe(r_oe), .kick_fault_output(f_od), .kick_fault_oe(f_oe), .irq(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  host_kicker host_u (.clk(clk), .hold(r_oe | f_oe), .en(en), .period(period), .kick(kick));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    if (v < lo || v > hi) chk(32'(v), 32'(lo));
    else chk(32'h0, 32'h0);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      test_done();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // counts edges until the chosen pull-down enable reaches lvl
  task automatic wait_oe(input logic f, input logic lvl, input int max);
    n = 0;
    while (((f ? f_oe : r_oe) !== lvl) && n < max) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_por_regs;
    chk(32'(f_oe), 32'h0);
    wait_oe(0, 0, 100);
    rng(n, RC, RC + 8);
    chk(32'(r_od), 32'h0);
    wb(0, ADDR_STATUS, 0);
    chk(q, 32'h0000_0008);
    wb(0, ADDR_LIVE, 0);
    chk(q, 32'h0000_0011);
    wb(0, ADDR_CAP_RST, 0);
    chk(q, CAP_RST_RESET);
    wb(0, ADDR_CAP_UPPER, 0);
    chk(q, CAP_UPPER_RESET);
    wb(1, 8'h20, 32'h5);
    wb(0, 8'h20, 0);
    chk(q, 32'h0);
  endtask

  task automatic t_rail;
    for (int i = 0; i < 2; i++) begin
      wb(1, ADDR_IRQ_CLEAR, 32'hf);
      wb(1, ADDR_IRQ_EN, 32'(i == 0));
      uv <= (i == 0);
      ov <= (i == 1);
      @(posedge clk);
      wait_oe(0, 1, 10);
      rng(n, 1, 6);
      wb(0, ADDR_STATUS, 0);
      chk(32'(q[EV_RAIL]), 32'h1);
      chk(32'(irq), 32'(i == 0));
      uv <= 1'b0;
      ov <= 1'b0;
      @(posedge clk);
      wait_oe(0, 0, 200);
      rng(n, RC, RC + 8);
      wb(1, ADDR_IRQ_CLEAR, 32'hf);
      wb(0, ADDR_STATUS, 0);
      chk(32'(irq), 32'h0);
    end
    rsel <= SEL_CAP;
    wb(1, ADDR_CAP_RST, 32'd60);
    uv <= 1'b1;
    wait_oe(0, 1, 10);
    uv <= 1'b0;
    @(posedge clk);
    wait_oe(0, 0, 200);
    rng(n, 60, 68);
    rsel <= SEL_OPEN;
  endtask

  task automatic t_upper;
    int up[3] = '{300, 400, 800};
    wb(1, ADDR_CAP_UPPER, 32'd300);
    en <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      wsel <= 2'(j);
      wait_oe(1, 1, 2000);
      chk(32'(r_oe), 32'h0);
      chk(32'(f_od), 32'h0);
      wait_oe(1, 0, 100);
      rng(n, RC, RC + 3);
      wb(1, ADDR_IRQ_CLEAR, 32'hf);
      wait_oe(1, 1, 2000);
      rng(n + 4, up[j] - 2, up[j] + 6);
      wb(0, ADDR_STATUS, 0);
      chk(32'(q[EV_LATE]), 32'h1);
      // let the late fault run out so the next setting is timed from a clean window
      wait_oe(1, 0, 100);
    end
    wsel <= SEL_PULLUP;
    en   <= 1'b1;
  endtask

  // strap code, kick period, fault expected
  task automatic t_straps;
    logic [1:0] code[8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
    int         per[8]  = '{30, 100, 150, 300, 70, 150, 10, 0};
    logic       f;
    for (int i = 0; i < 8; i++) begin
      {sb, sa} <= code[i];
      period   <= 16'(per[i]);
      en       <= (per[i] != 0);
      // a kick already due at the old period may still fault; let it finish
      repeat (8) @(posedge clk);
      wait_oe(1, 0, 100);
      wb(1, ADDR_IRQ_CLEAR, 32'hf);
      f = 1'b0;
      repeat (1000) begin
        @(posedge clk);
        if (f_oe === 1'b1) f = 1'b1;
      end
      chk(32'(f), 32'(i < 6 && i % 2 == 0));
      wb(0, ADDR_STATUS, 0);
      chk(32'(q[EV_EARLY]), 32'(i < 6 && i % 2 == 0));
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    fails++;
    test_done();
  end

  initial begin
    clk = 0; rstn = 0; uv = 0; ov = 0; sa = 0; sb = 0; en = 1; period = 16'd200;
    cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'hf; wdat = 32'h0;
    rsel = SEL_OPEN; wsel = SEL_PULLUP; fails = 0; num_checks = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_por_regs();
    t_rail();
    t_upper();
    t_straps();
    test_done();
  end
endmodule
`default_nettype wire
